// File: src/ccr_top.sv
//
// Purpose: register bank for two comparators and their programmable references
// Assumes: comparator results and enables are synchronous to hclk
// Notes:   analog ladders and decode tables live outside this block
//          hsize is ignored, every access is taken as a whole word
//          irq needs both gate bits set as well as an enabled status bit
//
`timescale 1ns/100ps

// Overview of operation
// - control bit 5 routes comparator B result and reference B to their pins, else port D.
// - control bit 1 routes comparator A result and reference A to their pins, else port C.
// - control bit 4 is a writable polarity choosing the active level of comparator B.
// - reference A select is an 8-bit writable register at index 9Bh, reset to zero.
// - reference B select is an 8-bit writable register at index 9Ch, reset to zero.
// - result bits 6 and 2 show the live comparator outputs and ignore writes.
// - the comparator flag holds while either result xor its polarity is one, not gated by enables.
// - select bits 7:3 pick the coarse tap and bits 2:0 the fine subdivision.
module ccr_top (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic                 comp_a_result,
	input  wire logic                 comp_b_result,
	output ccr_pkg::ccr_ref_sel_t     ref_a_sel,
	output ccr_pkg::ccr_ref_sel_t     ref_b_sel,
	output ccr_pkg::ccr_pin_en_t      pin_en,
	output logic                      comp_a_out_pin,
	output logic                      comp_b_out_pin,
	output logic                      comparator_irq_flag,
	output logic                      irq
);
	import ccr_pkg::*;

	// ********************************************************************
	// bus slave state
	// ********************************************************************
	logic         wr_pend_q, wr_pend_d;
	logic [7:0]   wr_idx_q,  wr_idx_d;
	logic [31:0]  rdata_q,   rdata_d;
	logic         ready_q,   ready_d;
	logic         resp_q,    resp_d;
	logic [7:0]   idx;
	logic         take;
	logic         wr_ref_a,  wr_ref_b,  wr_ctrl;
	logic         wr_clear,  wr_enable, wr_gates;

	// ********************************************************************
	// register state
	// ********************************************************************
	logic [7:0]   ref_a_q,   ref_a_d;
	logic [7:0]   ref_b_q,   ref_b_d;
	logic [7:0]   ctrl_q,    ctrl_d;
	logic [7:0]   ctrl_view;

	// ********************************************************************
	// per comparator state, index 0 is A and index 1 is B
	// ********************************************************************
	wire  [1:0]   result;
	wire  [1:0]   polarity;
	wire  [1:0]   active;
	wire  [1:0]   rise;
	wire  [1:0]   res_d;
	logic [1:0]   res_q;

	// ********************************************************************
	// interrupt state
	// ********************************************************************
	logic [2:0]   ista_q,    ista_d;
	logic [2:0]   ien_q,     ien_d;
	logic [1:0]   gates_q,   gates_d;
	logic [2:0]   events;
	logic         level;

	// ********************************************************************
	// output state
	// ********************************************************************
	ccr_ref_sel_t ref_a_sel_d, ref_b_sel_d;
	ccr_pin_en_t  pin_en_d;
	logic         comp_a_pin_d, comp_b_pin_d;
	logic         flag_d,    irq_d;

	// ********************************************************************
	// bus slave: zero wait states, always okay
	// ********************************************************************
	// word index from byte address
	assign idx  = haddr[9:2];
	assign take = hsel && hready && htrans[1];

	// address phase capture and read data
	always_comb begin
		wr_pend_d = 1'b0;
		wr_idx_d  = wr_idx_q;
		rdata_d   = rdata_q;
		ready_d   = 1'b1;                                      // no wait states
		resp_d    = 1'b0;                                      // always okay
		if (take) begin
			wr_pend_d = hwrite;
			wr_idx_d  = idx;
			rdata_d   = '0;
			if (!hwrite) begin
				case (idx)
					IDX_REF_A_SEL:  rdata_d[7:0] = ref_a_q;
					IDX_REF_B_SEL:  rdata_d[7:0] = ref_b_q;
					IDX_CMP_CTRL:   rdata_d[7:0] = ctrl_view;
					IDX_IRQ_STATUS: rdata_d[2:0] = ista_q;
					IDX_IRQ_ENABLE: rdata_d[2:0] = ien_q;
					IDX_IRQ_GATES:  rdata_d[1:0] = gates_q;
					default:        rdata_d      = '0;
				endcase
			end
		end
	end

	// bus registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= '0;
			rdata_q   <= '0;
			ready_q   <= 1'b1;
			resp_q    <= 1'b0;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_idx_q  <= wr_idx_d;
			rdata_q   <= rdata_d;
			ready_q   <= ready_d;
			resp_q    <= resp_d;
		end
	end

	// bus answer straight from flops
	assign hrdata    = rdata_q;
	assign hreadyout = ready_q;
	assign hresp     = resp_q;

	// write strobes in the data phase
	always_comb begin
		wr_ref_a  = 1'b0;
		wr_ref_b  = 1'b0;
		wr_ctrl   = 1'b0;
		wr_clear  = 1'b0;
		wr_enable = 1'b0;
		wr_gates  = 1'b0;
		if (wr_pend_q) begin
			case (wr_idx_q)
				IDX_REF_A_SEL:  wr_ref_a  = 1'b1;
				IDX_REF_B_SEL:  wr_ref_b  = 1'b1;
				IDX_CMP_CTRL:   wr_ctrl   = 1'b1;
				IDX_IRQ_CLEAR:  wr_clear  = 1'b1;
				IDX_IRQ_ENABLE: wr_enable = 1'b1;
				IDX_IRQ_GATES:  wr_gates  = 1'b1;
				default:        ;
			endcase
		end
	end

	// ********************************************************************
	// comparator channels
	// ********************************************************************
	// comparator inputs gathered per channel
	assign result   = {comp_b_result, comp_a_result};
	assign polarity = {ctrl_q[BIT_B_POL], ctrl_q[BIT_A_POL]};

	// active level, rising edge and history per comparator
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		assign active[ch] = result[ch] ^ polarity[ch];
		assign rise[ch]   = result[ch] & ~res_q[ch];
		assign res_d[ch]  = result[ch];
	end

	// result history for edge detection, idle low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_q <= '0;
		end else begin
			res_q <= res_d;
		end
	end

	// ********************************************************************
	// control and reference registers
	// ********************************************************************
	// live control view: results live, unimplemented bits zero
	always_comb begin
		ctrl_view                = ctrl_q & CTRL_WR_MASK;
		ctrl_view[BIT_A_RESULT]  = comp_a_result;
		ctrl_view[BIT_B_RESULT]  = comp_b_result;
	end

	// next register values
	always_comb begin
		ref_a_d = ref_a_q;
		ref_b_d = ref_b_q;
		ctrl_d  = ctrl_q;
		if (wr_ref_a) begin
			ref_a_d = hwdata[7:0];
		end
		if (wr_ref_b) begin
			ref_b_d = hwdata[7:0];
		end
		if (wr_ctrl) begin
			ctrl_d = hwdata[7:0] & CTRL_WR_MASK;
		end
	end

	// register state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_a_q <= RST_REF_SEL;
			ref_b_q <= RST_REF_SEL;
			ctrl_q  <= RST_CMP_CTRL;
		end else begin
			ref_a_q <= ref_a_d;
			ref_b_q <= ref_b_d;
			ctrl_q  <= ctrl_d;
		end
	end

	// ********************************************************************
	// interrupt status, enable and gates
	// ********************************************************************
	// events, clear and enable writes
	always_comb begin
		level                  = |active;
		events                 = '0;
		events[IRQ_BIT_LEVEL]  = level;
		events[IRQ_BIT_A_EDGE] = rise[0];
		events[IRQ_BIT_B_EDGE] = rise[1];
		ista_d                 = ista_q;
		ien_d                  = ien_q;
		gates_d                = gates_q;
		if (wr_clear) begin
			ista_d = ista_q & ~hwdata[2:0];
		end
		if (wr_enable) begin
			ien_d = hwdata[2:0];
		end
		if (wr_gates) begin
			gates_d = hwdata[1:0];
		end
		// set wins over clear
		ista_d = ista_d | events;
	end

	// interrupt state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ista_q  <= RST_IRQ;
			ien_q   <= RST_IRQ;
			gates_q <= '0;
		end else begin
			ista_q  <= ista_d;
			ien_q   <= ien_d;
			gates_q <= gates_d;
		end
	end

	// ********************************************************************
	// registered outputs
	// ********************************************************************
	// next output values, following the registers' next values
	always_comb begin
		ref_a_sel_d.coarse = ref_a_d[7:COARSE_LSB];
		ref_a_sel_d.fine   = ref_a_d[FINE_MSB:0];
		ref_b_sel_d.coarse = ref_b_d[7:COARSE_LSB];
		ref_b_sel_d.fine   = ref_b_d[FINE_MSB:0];
		pin_en_d.ref_a_en  = ctrl_d[BIT_A_PIN_EN];
		pin_en_d.cmp_a_en  = ctrl_d[BIT_A_PIN_EN];
		pin_en_d.ref_b_en  = ctrl_d[BIT_B_PIN_EN];
		pin_en_d.cmp_b_en  = ctrl_d[BIT_B_PIN_EN];
		comp_a_pin_d       = result[0];
		comp_b_pin_d       = result[1];
		flag_d             = level;
		irq_d              = (|(ista_d & ien_d)) & (&gates_d);
	end

	// output flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_a_sel           <= '0;
			ref_b_sel           <= '0;
			pin_en              <= '0;
			comp_a_out_pin      <= 1'b0;
			comp_b_out_pin      <= 1'b0;
			comparator_irq_flag <= 1'b0;
			irq                 <= 1'b0;
		end else begin
			ref_a_sel           <= ref_a_sel_d;
			ref_b_sel           <= ref_b_sel_d;
			pin_en              <= pin_en_d;
			comp_a_out_pin      <= comp_a_pin_d;
			comp_b_out_pin      <= comp_b_pin_d;
			comparator_irq_flag <= flag_d;
			irq                 <= irq_d;
		end
	end

endmodule : ccr_top

// File: pkg/ccr_pkg.sv
//
// Purpose: shared constants and types for the comparator reference control bank
// Assumes: AHB-Lite slave, 32-bit data, one aligned word per register
// Notes:   printed offsets are not all multiples of four, so they are indexes
//
package ccr_pkg;

	// ********************************************************************
	// register map
	// ********************************************************************
	localparam logic [7:0]  IDX_REF_A_SEL  = 8'h9B;
	localparam logic [7:0]  IDX_REF_B_SEL  = 8'h9C;
	localparam logic [7:0]  IDX_CMP_CTRL   = 8'h9D;
	localparam logic [7:0]  IDX_IRQ_STATUS = 8'hA0;
	localparam logic [7:0]  IDX_IRQ_CLEAR  = 8'hA1;
	localparam logic [7:0]  IDX_IRQ_ENABLE = 8'hA2;
	localparam logic [7:0]  IDX_IRQ_GATES  = 8'hA3;

	// ********************************************************************
	// field positions and reset values
	// ********************************************************************
	localparam int          BIT_A_POL      = 0;
	localparam int          BIT_A_PIN_EN   = 1;
	localparam int          BIT_A_RESULT   = 2;
	localparam int          BIT_B_POL      = 4;
	localparam int          BIT_B_PIN_EN   = 5;
	localparam int          BIT_B_RESULT   = 6;
	localparam logic [7:0]  CTRL_WR_MASK   = 8'h33;
	localparam int          FINE_MSB       = 2;
	localparam int          COARSE_LSB     = 3;
	localparam logic [7:0]  RST_REF_SEL    = 8'h00;
	localparam logic [7:0]  RST_CMP_CTRL   = 8'h00;
	localparam logic [2:0]  RST_IRQ        = 3'h0;
	localparam int          IRQ_BIT_LEVEL  = 0;
	localparam int          IRQ_BIT_A_EDGE = 1;
	localparam int          IRQ_BIT_B_EDGE = 2;

	// ********************************************************************
	// carriers
	// ********************************************************************
	typedef struct packed {
		logic [4:0] coarse;
		logic [2:0] fine;
	} ccr_ref_sel_t;

	typedef struct packed {
		logic       ref_a_en;
		logic       cmp_a_en;
		logic       ref_b_en;
		logic       cmp_b_en;
	} ccr_pin_en_t;

endpackage : ccr_pkg

// File: verification/ccr_chk.sv
// Purpose: port checker for the comparator reference bank
// Assumes: one hclk domain, hready fed from hreadyout
// Notes:   attached to ccr_top by bind at the foot
`timescale 1ns/100ps
module ccr_chk (
	input wire logic                  hclk,
	input wire logic                  hresetn,
	input wire logic                  hsel,
	input wire logic [31:0]           haddr,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic [31:0]           hwdata,
	input wire logic                  hready,
	input wire logic [31:0]           hrdata,
	input wire logic                  comp_a_result,
	input wire ccr_pkg::ccr_ref_sel_t ref_a_sel,
	input wire ccr_pkg::ccr_ref_sel_t ref_b_sel,
	input wire ccr_pkg::ccr_pin_en_t  pin_en,
	input wire logic                  comp_a_out_pin,
	input wire logic                  comparator_irq_flag,
	input wire logic                  irq
);
	import ccr_pkg::*;
	// ********************************************************************
	// bus access relations
	// ********************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// taken access of one kind to one index
	sequence acc(logic [7:0] i, logic w);
		hsel && hready && htrans[1] && hwrite == w && haddr[9:2] == i;
	endsequence
	AST_PIN_B: assert property (acc(IDX_CMP_CTRL, 1'b0) |=>
		hrdata[5] == $past(pin_en.cmp_b_en) && hrdata[5] == $past(pin_en.ref_b_en))
		else $error("pin enable b mismatch");
	AST_PIN_A: assert property (acc(IDX_CMP_CTRL, 1'b0) |=>
		hrdata[1] == $past(pin_en.cmp_a_en) && hrdata[1] == $past(pin_en.ref_a_en))
		else $error("pin enable a mismatch");
	AST_RESULT: assert property (acc(IDX_CMP_CTRL, 1'b0) |=>
		hrdata[2] == $past(comp_a_result)) else $error("result bit not live");
	AST_UNIMP: assert property (acc(IDX_CMP_CTRL, 1'b0) |=>
		hrdata[31:7] == 25'h0 && !hrdata[3]) else $error("unused bits not zero");
	AST_REF_A: assert property (acc(IDX_REF_A_SEL, 1'b0) |=>
		hrdata == {24'h0, $past(ref_a_sel)}) else $error("ref a readback");
	AST_REF_B: assert property (acc(IDX_REF_B_SEL, 1'b0) |=>
		hrdata == {24'h0, $past(ref_b_sel)}) else $error("ref b readback");
	AST_WR_A: assert property (acc(IDX_REF_A_SEL, 1'b1) ##1 1'b1 |=>
		ref_a_sel == $past(hwdata[7:0])) else $error("ref a write lost");
	AST_FIELDS: assert property (acc(IDX_REF_B_SEL, 1'b1) ##1 1'b1 |=>
		ref_b_sel.coarse == $past(hwdata[7:3]) && ref_b_sel.fine == $past(hwdata[2:0]))
		else $error("ref b fields");
	AST_OUT_A: assert property (pin_en.cmp_a_en && $past(pin_en.cmp_a_en) |->
		comp_a_out_pin == $past(comp_a_result)) else $error("pin a result");
	// main scenarios reached
	cover property (acc(IDX_CMP_CTRL, 1'b1));
	cover property (comparator_irq_flag);
	cover property (irq);
endmodule : ccr_chk
bind ccr_top ccr_chk u_ccr_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.comp_a_result(comp_a_result), .ref_a_sel(ref_a_sel), .ref_b_sel(ref_b_sel),
	.pin_en(pin_en), .comp_a_out_pin(comp_a_out_pin),
	.comparator_irq_flag(comparator_irq_flag), .irq(irq));

// File: verification/comparator_reference_ctrl_tb_top.sv
// Purpose: self-checking bench for the comparator reference bank
// Assumes: one AHB-Lite master, hready fed from hreadyout
// Notes:   scenarios run in turn after one reset
`timescale 1ns/100ps
module comparator_reference_ctrl_tb_top;
	import ccr_pkg::*;
	logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic         comp_a_result = 1'b0, comp_b_result = 1'b0;
	logic [1:0]   htrans = 2'h0;
	logic [2:0]   hsize = 3'h0;
	logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
	logic         hreadyout, hresp, comp_a_out_pin, comp_b_out_pin, comparator_irq_flag, irq;
	ccr_ref_sel_t ref_a_sel, ref_b_sel;
	ccr_pin_en_t  pin_en;
	int           failures = 0, cmp_count = 0;
	ccr_top u_ccr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_a_result(comp_a_result),
		.comp_b_result(comp_b_result), .ref_a_sel(ref_a_sel), .ref_b_sel(ref_b_sel),
		.pin_en(pin_en), .comp_a_out_pin(comp_a_out_pin), .comp_b_out_pin(comp_b_out_pin),
		.comparator_irq_flag(comparator_irq_flag), .irq(irq));
	// ********************************************************************
	// bus and check helpers
	// ********************************************************************
	always #2 hclk = ~hclk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one single transfer, address phase then data phase
	task xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge hclk);
		{hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'h2, w, 3'h2, 22'h0, i, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask : xfer
	task wr(input logic [7:0] i, input logic [31:0] d);
		xfer(1'b1, i, d);
	endtask : wr
	task rdc(input logic [7:0] i, input logic [31:0] e);
		xfer(1'b0, i, 32'h0);
		chk(rv, e);
		chk(hresp, 32'h0);
	endtask : rdc
	task settle;
		repeat (3) @(posedge hclk);
		#1;
	endtask : settle
	task t_reset;
		rdc(IDX_REF_A_SEL, 32'h0);
		rdc(IDX_REF_B_SEL, 32'h0);
		rdc(IDX_CMP_CTRL, 32'h0);
	endtask : t_reset
	task t_refs;
		wr(IDX_REF_A_SEL, 32'hFFFF_FF5A);
		rdc(IDX_REF_A_SEL, 32'h5A);
		wr(IDX_REF_B_SEL, 32'hC3);
		rdc(IDX_REF_B_SEL, 32'hC3);
		chk(ref_a_sel.coarse, 32'h0B);
		chk(ref_a_sel.fine, 32'h2);
		chk(ref_b_sel.coarse, 32'h18);
		chk(ref_b_sel.fine, 32'h3);
		rdc(8'h10, 32'h0);
	endtask : t_refs
	task t_ctrl;
		wr(IDX_CMP_CTRL, 32'hFF);
		rdc(IDX_CMP_CTRL, 32'h33);
		chk(pin_en, 32'hF);
		@(posedge hclk) {comp_a_result, comp_b_result} <= 2'b10;
		settle;
		chk(comp_a_out_pin, 1'b1);
		rdc(IDX_CMP_CTRL, 32'h37);
		wr(IDX_CMP_CTRL, 32'h0);
		settle;
		chk(pin_en, 32'h0);
	endtask : t_ctrl
	task t_irq;
		wr(IDX_IRQ_GATES, 32'h3);
		wr(IDX_IRQ_ENABLE, 32'h1);
		settle;
		chk(comparator_irq_flag, 1'b1);
		chk(irq, 1'b1);
		wr(IDX_IRQ_GATES, 32'h1);
		settle;
		chk(irq, 1'b0);
		wr(IDX_IRQ_GATES, 32'h3);
		settle;
		chk(irq, 1'b1);
		wr(IDX_IRQ_ENABLE, 32'h0);
		settle;
		chk(irq, 1'b0);
		wr(IDX_CMP_CTRL, 32'h01);
		settle;
		chk(comparator_irq_flag, 1'b0);
		@(posedge hclk) comp_b_result <= 1'b1;
		settle;
		chk(comparator_irq_flag, 1'b1);
		chk(comp_b_out_pin, 1'b1);
		wr(IDX_CMP_CTRL, 32'h11);
		settle;
		chk(comparator_irq_flag, 1'b0);
		xfer(1'b0, IDX_IRQ_STATUS, 32'h0);
		chk(rv, 32'h7);
		wr(IDX_IRQ_CLEAR, 32'h7);
		rdc(IDX_IRQ_STATUS, 32'h0);
	endtask : t_irq
	task complete_run;
		if (failures == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	// main sequence after a five cycle reset
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_refs;
		t_ctrl;
		t_irq;
		complete_run;
	end
	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge hclk);
		failures++;
		complete_run;
	end
endmodule : comparator_reference_ctrl_tb_top
